// ---- relay_threshold_controller.sv ----
// Relay threshold controller with AXI4-Lite register slave
//
// Overview of operation
// [RULE_01] Independent configuration per relay; LED-only if unfitted
// [RULE_02] Compare present value or active peak value
// [RULE_03] Primary threshold signed, -999 to 9999
// [RULE_04] Secondary threshold used only in window modes
// [RULE_05] Change only outside threshold plus/minus half-band
// [RULE_06] Inactive mode holds relay off
// [RULE_07] Normal mode: on above band, off below
// [RULE_08] Inverted mode: off above band, on below
// [RULE_09] Inside window on, thresholds ordered internally
// [RULE_10] Outside window on, inside window off
// [RULE_11] Remote mode follows bus master commands
// [RULE_12] Remote relay state lost at power-up
// [RULE_13] LED lit exactly while relay closed
// [RULE_14] Turn on after condition persists for delay
// [RULE_15] Turn off after condition persists for delay
// [RULE_16] Time base selects seconds or minutes
// [RULE_17] Critical reaction: hold, force on, force off
// [RULE_18] Threshold modes: range exceeded is critical
// [RULE_19] Remote mode: bus silence is critical
// [RULE_20] Force-on reaction overrides inactive mode
// [RULE_21] Audible_alert_menu on critical or enabled relay activation
// [RULE_22] Any button press silences audible_alert_menu
// [RULE_23] Pending delay restarts when condition vanishes
`timescale 1ns/1ps
module relay_threshold_controller #(
   parameter int TICK_CYCLES = relay_ctrl_pkg::TENTH_CYCLES
) (
   input  wire logic                     clk_sys,
   input  wire logic                     rstn,
   input  wire relay_ctrl_pkg::axiReq_t  axiReq,
   output relay_ctrl_pkg::axiRsp_t       axiRsp,
   input  wire logic signed [15:0]       measValue,
   input  wire logic signed [15:0]       peakValue,
   input  wire logic                     peakActive,
   input  wire logic                     rangeExceeded,
   input  wire logic [3:0]               buttonPins,
   output logic [3:0]                    relayOut,
   output logic [3:0]                    ledOut,
   output logic                          beepOut
);
   import relay_ctrl_pkg::*;

   // ==========================================================
   // Helper functions
   function automatic logic [31:0] mergeStrb(input logic [31:0] oldW,
                                             input logic [31:0] newW,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = oldW;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = newW[b*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic isRelayAddr(input logic [7:0] a);
      return (a >= ADDR_RELAY0) && (a < ADDR_RELAY_END) && (a[3:2] != 2'h3);
   endfunction

   function automatic logic [1:0] relayIdx(input logic [7:0] a);
      logic [3:0] blk;
      blk = a[7:4] - 4'h1;
      return blk[1:0];
   endfunction

   // Value beyond threshold plus half-band
   function automatic logic aboveBand(input logic signed [15:0] x,
                                      input logic signed [15:0] t,
                                      input logic [9:0]         hb);
      return 18'(signed'(x)) > (18'(signed'(t)) + signed'(18'(hb)));
   endfunction

   // Value beneath threshold minus half-band
   function automatic logic belowBand(input logic signed [15:0] x,
                                      input logic signed [15:0] t,
                                      input logic [9:0]         hb);
      return 18'(signed'(x)) < (18'(signed'(t)) - signed'(18'(hb)));
   endfunction

   // ==========================================================
   // Register storage
   logic [31:0]        thrReg_q [NUM_RELAYS];
   logic [31:0]        cfgReg_q [NUM_RELAYS];
   logic [31:0]        dlyReg_q [NUM_RELAYS];
   logic               alarmBeepEn_q;
   logic [15:0]        silenceLimit_q;
   logic [3:0]         remoteCmd_q;
   logic               remoteWrite;
   logic [31:0]        ctrlMerged;

   // ==========================================================
   // AXI4-Lite write channel
   logic               awHeld_q;
   logic               wHeld_q;
   logic [7:0]         awAddr_q;
   logic [31:0]        wData_q;
   logic [3:0]         wStrb_q;
   logic               bValid_q;
   logic [1:0]         bResp_q;
   logic               doWrite;

   assign axiRsp.awready = !awHeld_q && !bValid_q;
   assign axiRsp.wready  = !wHeld_q && !bValid_q;
   assign axiRsp.bvalid  = bValid_q;
   assign axiRsp.bresp   = bResp_q;
   assign doWrite        = awHeld_q && wHeld_q && !bValid_q;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         awHeld_q <= 1'b0;
         awAddr_q <= 8'h00;
      end else if (axiReq.awvalid && axiRsp.awready) begin
         awHeld_q <= 1'b1;
         awAddr_q <= axiReq.awaddr;
      end else if (doWrite) begin
         awHeld_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wHeld_q <= 1'b0;
         wData_q <= ZERO_WORD;
         wStrb_q <= 4'h0;
      end else if (axiReq.wvalid && axiRsp.wready) begin
         wHeld_q <= 1'b1;
         wData_q <= axiReq.wdata;
         wStrb_q <= axiReq.wstrb;
      end else if (doWrite) begin
         wHeld_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         bValid_q <= 1'b0;
         bResp_q  <= RESP_OKAY;
      end else if (doWrite) begin
         bValid_q <= 1'b1;
         if (awAddr_q == ADDR_CTRL || awAddr_q == ADDR_REMOTE || awAddr_q == ADDR_STATUS ||
             isRelayAddr(awAddr_q)) begin
            bResp_q <= RESP_OKAY;
         end else begin
            bResp_q <= RESP_SLVERR;
         end
      end else if (bValid_q && axiReq.bready) begin
         bValid_q <= 1'b0;
      end
   end

   // ==========================================================
   // Register writes
   assign remoteWrite = doWrite && (awAddr_q == ADDR_REMOTE);
   assign ctrlMerged  = mergeStrb({silenceLimit_q, 15'h0000, alarmBeepEn_q}, wData_q, wStrb_q);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         alarmBeepEn_q  <= 1'b0;
         silenceLimit_q <= 16'h0000;
      end else if (doWrite && awAddr_q == ADDR_CTRL) begin
         {silenceLimit_q, alarmBeepEn_q} <= {ctrlMerged[31:16], ctrlMerged[0]};
      end
   end

   // Commands from the serial master; cleared at power-up, never retained
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         remoteCmd_q <= 4'h0; // [RULE_12]
      end else if (remoteWrite && wStrb_q[0]) begin
         remoteCmd_q <= wData_q[3:0]; // [RULE_11]
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_RELAYS; i++) begin
            thrReg_q[i] <= ZERO_WORD;
            cfgReg_q[i] <= CFG_RESET;
            dlyReg_q[i] <= ZERO_WORD;
         end
      end else if (doWrite && isRelayAddr(awAddr_q)) begin
         case (awAddr_q[3:2])
            WORD_THR: thrReg_q[relayIdx(awAddr_q)] <=
                         mergeStrb(thrReg_q[relayIdx(awAddr_q)], wData_q, wStrb_q); // [RULE_01]
            WORD_CFG: cfgReg_q[relayIdx(awAddr_q)] <=
                         mergeStrb(cfgReg_q[relayIdx(awAddr_q)], wData_q, wStrb_q); // [RULE_01]
            WORD_DLY: dlyReg_q[relayIdx(awAddr_q)] <=
                         mergeStrb(dlyReg_q[relayIdx(awAddr_q)], wData_q, wStrb_q); // [RULE_01]
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Time base: tenth of a second, tenth of a minute
   logic [31:0]        tenthCnt_q;
   logic [5:0]         minCnt_q;
   logic               tenthTick;
   logic               minTick;
   logic [15:0]        silenceCnt_q;
   logic               linkSilent;

   assign tenthTick = (tenthCnt_q == 32'(TICK_CYCLES - 1));
   assign minTick   = tenthTick && (minCnt_q == TENTHS_PER_MIN - 6'h01);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         tenthCnt_q <= 32'h00000000;
      end else if (tenthTick) begin
         tenthCnt_q <= 32'h00000000;
      end else begin
         tenthCnt_q <= tenthCnt_q + 32'h00000001;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         minCnt_q <= 6'h00;
      end else if (minTick) begin
         minCnt_q <= 6'h00;
      end else if (tenthTick) begin
         minCnt_q <= minCnt_q + 6'h01;
      end
   end

   // Bus silence watch, restarted by every command write
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         silenceCnt_q <= 16'h0000;
      end else if (remoteWrite) begin
         silenceCnt_q <= 16'h0000;
      end else if (tenthTick && silenceCnt_q != 16'hFFFF) begin
         silenceCnt_q <= silenceCnt_q + 16'h0001;
      end
   end

   assign linkSilent = (silenceCnt_q > silenceLimit_q); // [RULE_19]

   // ==========================================================
   // Per-relay comparison and switching
   logic [3:0]         relayState;
   logic [3:0]         critical;
   logic [3:0]         target;
   logic [3:0]         fitted;
   logic [3:0]         beepEn;

   for (genvar g = 0; g < NUM_RELAYS; g++) begin : gRelay
      thrWord_t           thr;
      cfgWord_t           cfg;
      dlyWord_t           dly;
      logic signed [15:0] x;
      logic signed [15:0] lo;
      logic signed [15:0] hi;
      logic               bypass;

      assign thr    = thrWord_t'(thrReg_q[g]);
      assign cfg    = cfgWord_t'(cfgReg_q[g]);
      assign dly    = dlyWord_t'(dlyReg_q[g]);
      assign x      = (cfg.usePeak && peakActive) ? peakValue : measValue; // [RULE_02]
      assign lo     = (thr.primary < thr.secondary) ? thr.primary : thr.secondary; // [RULE_09]
      assign hi     = (thr.primary < thr.secondary) ? thr.secondary : thr.primary; // [RULE_09]
      assign bypass = (cfg.mode == MODE_INACTIVE) || (cfg.mode == MODE_REMOTE);
      assign fitted[g] = cfg.fitted;
      assign beepEn[g] = cfg.beepEnable;

      // Threshold modes watch the measuring range, remote mode the bus
      assign critical[g] = (cfg.mode == MODE_REMOTE) ? linkSilent : rangeExceeded; // [RULE_18] [RULE_19]

      // Inside the hysteresis band the present state is kept
      always_comb begin
         target[g] = relayState[g];
         case (cfg.mode)
            MODE_INACTIVE: target[g] = 1'b0; // [RULE_06]
            MODE_NORMAL: begin
               if (aboveBand(x, thr.primary, cfg.halfBand)) begin
                  target[g] = 1'b1; // [RULE_07] [RULE_03] [RULE_05]
               end else if (belowBand(x, thr.primary, cfg.halfBand)) begin
                  target[g] = 1'b0; // [RULE_07] [RULE_05]
               end
            end
            MODE_INVERTED: begin
               if (aboveBand(x, thr.primary, cfg.halfBand)) begin
                  target[g] = 1'b0; // [RULE_08] [RULE_05]
               end else if (belowBand(x, thr.primary, cfg.halfBand)) begin
                  target[g] = 1'b1; // [RULE_08] [RULE_05]
               end
            end
            MODE_INSIDE: begin
               if (aboveBand(x, lo, cfg.halfBand) && belowBand(x, hi, cfg.halfBand)) begin
                  target[g] = 1'b1; // [RULE_09] [RULE_04]
               end else if (belowBand(x, lo, cfg.halfBand) || aboveBand(x, hi, cfg.halfBand)) begin
                  target[g] = 1'b0; // [RULE_09]
               end
            end
            MODE_OUTSIDE: begin
               if (aboveBand(x, hi, cfg.halfBand) || belowBand(x, lo, cfg.halfBand)) begin
                  target[g] = 1'b1; // [RULE_10] [RULE_04]
               end else if (aboveBand(x, lo, cfg.halfBand) && belowBand(x, hi, cfg.halfBand)) begin
                  target[g] = 1'b0; // [RULE_10]
               end
            end
            MODE_REMOTE: target[g] = remoteCmd_q[g]; // [RULE_11]
            default:     target[g] = 1'b0;
         endcase
      end

      relay_delay_unit uDelay (
         .clk_sys  (clk_sys),
         .rstn     (rstn),
         .tick     (cfg.timeInMinutes ? minTick : tenthTick), // [RULE_16]
         .target   (target[g]),
         .bypass   (bypass),
         .critical (critical[g]),
         .reaction (cfg.reaction),
         .onDelay  (dly.onDelay),
         .offDelay (dly.offDelay),
         .state    (relayState[g])
      );
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         relayOut <= 4'h0;
         ledOut   <= 4'h0;
      end else begin
         relayOut <= relayState & fitted; // [RULE_01]
         ledOut   <= relayState; // [RULE_13] [RULE_01]
      end
   end

   // ==========================================================
   // Acoustic alert
   logic [3:0]         btnSync1_q;
   logic [3:0]         btnSync2_q;
   logic [3:0]         btnPrev_q;
   logic               btnPress;
   logic [3:0]         statePrev_q;
   logic               critPrev_q;
   logic               beepSet;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         btnSync1_q  <= 4'h0;
         btnSync2_q  <= 4'h0;
         btnPrev_q   <= 4'h0;
         statePrev_q <= 4'h0;
         critPrev_q  <= 1'b0;
      end else begin
         btnSync1_q  <= buttonPins;
         btnSync2_q  <= btnSync1_q;
         btnPrev_q   <= btnSync2_q;
         statePrev_q <= relayState;
         critPrev_q  <= |critical;
      end
   end

   assign btnPress = |(btnSync2_q & ~btnPrev_q);
   assign beepSet  = (alarmBeepEn_q && (|critical) && !critPrev_q) || // [RULE_21]
                     (|(relayState & ~statePrev_q & beepEn)); // [RULE_21]

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         beepOut <= 1'b0;
      end else if (beepSet) begin
         beepOut <= 1'b1; // [RULE_21]
      end else if (btnPress) begin
         beepOut <= 1'b0; // [RULE_22]
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   logic               rValid_q;
   logic [31:0]        rData_q;
   logic [1:0]         rResp_q;

   assign axiRsp.arready = !rValid_q;
   assign axiRsp.rvalid  = rValid_q;
   assign axiRsp.rdata   = rData_q;
   assign axiRsp.rresp   = rResp_q;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rValid_q <= 1'b0;
         rData_q  <= ZERO_WORD;
         rResp_q  <= RESP_OKAY;
      end else if (axiReq.arvalid && !rValid_q) begin
         rValid_q <= 1'b1;
         rResp_q  <= RESP_OKAY;
         if (axiReq.araddr == ADDR_CTRL) begin
            rData_q <= {silenceLimit_q, 15'h0000, alarmBeepEn_q};
         end else if (axiReq.araddr == ADDR_REMOTE) begin
            rData_q <= {28'h0000000, remoteCmd_q};
         end else if (axiReq.araddr == ADDR_STATUS) begin
            rData_q <= {22'h000000, linkSilent, beepOut, critical, relayState};
         end else if (isRelayAddr(axiReq.araddr)) begin
            case (axiReq.araddr[3:2])
               WORD_THR: rData_q <= thrReg_q[relayIdx(axiReq.araddr)];
               WORD_CFG: rData_q <= cfgReg_q[relayIdx(axiReq.araddr)];
               default:  rData_q <= dlyReg_q[relayIdx(axiReq.araddr)];
            endcase
         end else begin
            rData_q <= ZERO_WORD;
            rResp_q <= RESP_SLVERR;
         end
      end else if (rValid_q && axiReq.rready) begin
         rValid_q <= 1'b0;
      end
   end

endmodule

// ---- relay_ctrl_pkg.sv ----
// Package with constants, field layouts and carrier types of the relay threshold controller
package relay_ctrl_pkg;

   // ==========================================================
   // Sizes and timing
   localparam int          NUM_RELAYS     = 4;
   localparam int          CLK_PERIOD_NS  = 50;
   localparam longint      TENTH_SEC_NS   = 100000000;
   localparam int          TENTH_CYCLES   = int'(TENTH_SEC_NS / CLK_PERIOD_NS);
   localparam logic [5:0]  TENTHS_PER_MIN = 6'h3C;

   // ==========================================================
   // Register byte addresses
   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_REMOTE    = 8'h04;
   localparam logic [7:0]  ADDR_STATUS    = 8'h08;
   localparam logic [7:0]  ADDR_RELAY0    = 8'h10;
   localparam logic [7:0]  ADDR_RELAY_END = 8'h50;
   localparam logic [1:0]  WORD_THR       = 2'h0;
   localparam logic [1:0]  WORD_CFG       = 2'h1;
   localparam logic [1:0]  WORD_DLY       = 2'h2;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam logic [31:0] CFG_RESET      = 32'h00040000;
   localparam logic [31:0] ZERO_WORD      = 32'h00000000;

   // ==========================================================
   // Operating modes and critical reactions
   localparam logic [2:0]  MODE_INACTIVE  = 3'h0;
   localparam logic [2:0]  MODE_NORMAL    = 3'h1;
   localparam logic [2:0]  MODE_INVERTED  = 3'h2;
   localparam logic [2:0]  MODE_INSIDE    = 3'h3;
   localparam logic [2:0]  MODE_OUTSIDE   = 3'h4;
   localparam logic [2:0]  MODE_REMOTE    = 3'h5;
   localparam logic [1:0]  REACT_HOLD     = 2'h0;
   localparam logic [1:0]  REACT_ON       = 2'h1;
   localparam logic [1:0]  REACT_OFF      = 2'h2;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic signed [15:0] secondary;
      logic signed [15:0] primary;
   } thrWord_t;

   typedef struct packed {
      logic [12:0] unused;
      logic        fitted;
      logic        beepEnable;
      logic [1:0]  reaction;
      logic        timeInMinutes;
      logic        usePeak;
      logic [2:0]  mode;
      logic [9:0]  halfBand;
   } cfgWord_t;

   typedef struct packed {
      logic [5:0] unusedHi;
      logic [9:0] offDelay;
      logic [5:0] unusedLo;
      logic [9:0] onDelay;
   } dlyWord_t;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } axiReq_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axiRsp_t;

endpackage

// ---- relay_delay_unit.sv ----
// Per-relay turn-on and turn-off delay and critical override
`timescale 1ns/1ps
module relay_delay_unit (
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       tick,
   input  wire logic       target,
   input  wire logic       bypass,
   input  wire logic       critical,
   input  wire logic [1:0] reaction,
   input  wire logic [9:0] onDelay,
   input  wire logic [9:0] offDelay,
   output logic            state
);
   import relay_ctrl_pkg::*;

   logic [9:0] cnt_q;
   logic [9:0] limit;

   assign limit = state ? offDelay : onDelay;

   // ==========================================================
   // Relay state
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= 1'b0;
      end else if (critical) begin
         case (reaction)
            REACT_ON:  state <= 1'b1; // [RULE_17] [RULE_20]
            REACT_OFF: state <= 1'b0; // [RULE_17]
            default:   state <= state; // [RULE_17]
         endcase
      end else if (bypass) begin
         state <= target; // [RULE_06] [RULE_11]
      end else if (target != state && cnt_q >= limit) begin
         state <= target; // [RULE_14] [RULE_15]
      end
   end

   // ==========================================================
   // Persistence counter, restarted whenever the condition drops
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 10'h000;
      end else if (critical || bypass || target == state) begin
         cnt_q <= 10'h000; // [RULE_23]
      end else if (cnt_q >= limit) begin
         cnt_q <= 10'h000;
      end else if (tick) begin
         cnt_q <= cnt_q + 10'h001; // [RULE_14] [RULE_15]
      end
   end

endmodule

// ---- relay_panel_model.sv ----
// Front panel model that presses one button on request
`timescale 1ns/1ps
module relay_panel_model (
   input  wire logic  clk_sys,
   input  wire logic  press,
   output logic [3:0] buttonPins
);
   // ==========
   // One middle key only, since any key must silence the alert
   always_ff @(posedge clk_sys) begin
      buttonPins <= {1'b0, press, 2'b00};
   end
endmodule

// ---- relay_threshold_controller_chk.sv ----
// Port checker of the relay threshold controller
`timescale 1ns/1ps
module relay_threshold_controller_chk #(
   parameter int TICK_CYCLES = 10
) (
   input wire logic                    clk_sys,
   input wire logic                    rstn,
   input wire relay_ctrl_pkg::axiReq_t axiReq,
   input wire relay_ctrl_pkg::axiRsp_t axiRsp,
   input wire logic [3:0]              buttonPins,
   input wire logic [3:0]              relayOut,
   input wire logic [3:0]              ledOut,
   input wire logic                    beepOut
);
   import relay_ctrl_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // ==========
   // Assertions
   led_follow_a: assert property ((relayOut & ~ledOut) == 4'h0)
      else $error("closed relay with dark led");
   rst_clear_a: assert property ($rose(rstn) |-> relayOut == 4'h0 && !beepOut)
      else $error("outputs not clear after reset");
   audible_alert_menu_quiet_a: assert property ($fell(beepOut) |-> |$past(buttonPins, 3))
      else $error("alert dropped without a key");
   rd_answer_a: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
      else $error("read not answered");
   rd_hold_a: assert property (axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
      else $error("read data not held");
   wr_hold_a: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
      else $error("write response not held");
   wr_block_a: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
      else $error("write taken during response");
   wr_free_a: assert property (axiRsp.bvalid && axiReq.bready |=> axiRsp.awready && axiRsp.wready)
      else $error("write channel not freed");
   cover property ($rose(beepOut));
   cover property ($rose(relayOut[0]));
   cover property ($fell(relayOut[0]));
   cover property (axiRsp.rvalid && axiRsp.rresp == RESP_SLVERR);
endmodule

bind relay_threshold_controller relay_threshold_controller_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
   .clk_sys(clk_sys), .rstn(rstn), .axiReq(axiReq), .axiRsp(axiRsp), .buttonPins(buttonPins),
   .relayOut(relayOut), .ledOut(ledOut), .beepOut(beepOut));

// ---- relay_threshold_controller_tb_top.sv ----
// Self-checking bench of the relay threshold controller
`timescale 1ns/1ps
module relay_threshold_controller_tb_top;
   import relay_ctrl_pkg::*;
   logic               clk_sys = 1'b0;
   logic               rstn = 1'b0;
   axiReq_t            req = '0;
   axiRsp_t            rsp;
   logic signed [15:0] measValue = 16'h0000;
   logic               rangeExceeded = 1'b0;
   logic               press = 1'b0;
   logic               peakActive = 1'b0;
   logic [3:0]         buttonPins;
   logic [3:0]         relayOut;
   logic [3:0]         ledOut;
   logic               beepOut;
   int                 error_cnt = 0;
   int                 samples_checked = 0;

   initial begin
      forever #25 clk_sys = ~clk_sys;
   end

   relay_threshold_controller #(.TICK_CYCLES(10)) i_relay_threshold_controller (
      .clk_sys(clk_sys), .rstn(rstn), .axiReq(req), .axiRsp(rsp), .measValue(measValue),
      .peakValue(16'h0096), .peakActive(peakActive), .rangeExceeded(rangeExceeded),
      .buttonPins(buttonPins), .relayOut(relayOut), .ledOut(ledOut), .beepOut(beepOut));
   relay_panel_model i_relay_panel_model (.clk_sys(clk_sys), .press(press), .buttonPins(buttonPins));

   // ==========
   // Shared tasks
   task test_done;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task tmo(input int n);
      if (n >= 50) begin
         error_cnt++;
         test_done();
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      req <= {1'b1, a, 1'b1, d, 4'hF, 1'b1, req.arvalid, req.araddr, req.rready};
      do begin
         @(posedge clk_sys);
         n++;
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid && n < 50);
      req.bready <= 1'b0;
      tmo(n);
      chk(rsp.bresp, RESP_OKAY);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk_sys);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid && n < 50);
      req.rready <= 1'b0;
      tmo(n);
      chk(rsp.rdata, e);
      chk(rsp.rresp, r);
   endtask

   task mv(input logic signed [15:0] v, input int n, input logic [3:0] e);
      measValue <= v;
      repeat (n) @(posedge clk_sys);
      chk(relayOut, e);
      chk(ledOut, e);
   endtask

   function automatic logic [31:0] cf(input logic [2:0] m, input logic [9:0] hb, input logic [1:0] r);
      return {13'h0000, 2'h2, r, 2'h0, m, hb};
   endfunction

   // ==========
   // Scenarios
   task t_regs;
      rd(ADDR_RELAY0 + 8'h04, CFG_RESET, RESP_OKAY);
      rd(8'h1C, ZERO_WORD, RESP_SLVERR);
      chk(relayOut, 4'h0);
   endtask

   task t_single;
      wr(ADDR_RELAY0, 32'h00000064);
      wr(ADDR_RELAY0 + 8'h04, cf(MODE_NORMAL, 10'h00A, REACT_HOLD));
      mv(16'h006E, 4, 4'h0);
      mv(16'h006F, 4, 4'h1);
      mv(16'h005A, 4, 4'h1);
      mv(16'h0059, 4, 4'h0);
      wr(ADDR_RELAY0 + 8'h04, cf(MODE_INVERTED, 10'h00A, REACT_HOLD));
      mv(16'h0059, 4, 4'h1);
      mv(16'h006F, 4, 4'h0);
   endtask

   task t_window;
      wr(ADDR_RELAY0, 32'h006400C8);
      wr(ADDR_RELAY0 + 8'h04, cf(MODE_INSIDE, 10'h005, REACT_HOLD));
      mv(16'h0096, 4, 4'h1);
      mv(16'h00FA, 4, 4'h0);
      wr(ADDR_RELAY0 + 8'h04, cf(MODE_OUTSIDE, 10'h005, REACT_HOLD));
      mv(16'h0096, 4, 4'h0);
      mv(16'h0032, 4, 4'h1);
   endtask

   task t_delay;
      wr(ADDR_RELAY0 + 8'h08, 32'h00020003);
      wr(ADDR_RELAY0, 32'h00000064);
      wr(ADDR_RELAY0 + 8'h04, cf(MODE_NORMAL, 10'h00A, REACT_HOLD));
      mv(16'h0032, 45, 4'h0);
      mv(16'h0096, 15, 4'h0);
      mv(16'h0032, 4, 4'h0);
      mv(16'h0096, 45, 4'h1);
      mv(16'h0032, 8, 4'h1);
      mv(16'h0032, 35, 4'h0);
   endtask

   task t_crit;
      wr(ADDR_CTRL, 32'h00000001);
      wr(ADDR_RELAY0 + 8'h04, cf(MODE_INACTIVE, 10'h000, REACT_ON));
      rangeExceeded <= 1'b1;
      mv(16'h0032, 4, 4'h1);
      chk(beepOut, 1'b1);
      press <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk(beepOut, 1'b0);
      press <= 1'b0;
      rangeExceeded <= 1'b0;
      mv(16'h0032, 4, 4'h0);
      wr(ADDR_RELAY0 + 8'h08, ZERO_WORD);
      wr(ADDR_RELAY0 + 8'h04, cf(MODE_NORMAL, 10'h00A, REACT_OFF));
      mv(16'h0096, 4, 4'h1);
      rangeExceeded <= 1'b1;
      mv(16'h0096, 4, 4'h0);
      rangeExceeded <= 1'b0;
   endtask

   task t_remote;
      wr(ADDR_CTRL, 32'h00050000);
      wr(ADDR_RELAY0 + 8'h04, cf(MODE_REMOTE, 10'h000, REACT_OFF));
      wr(ADDR_REMOTE, 32'h00000001);
      mv(16'h0032, 4, 4'h1);
      mv(16'h0032, 80, 4'h0);
      wr(ADDR_RELAY0, 32'h0000FFF6);
      wr(ADDR_RELAY0 + 8'h04, cf(MODE_NORMAL, 10'h00A, REACT_HOLD) | 32'h00002000);
      mv(16'hFFE2, 4, 4'h0);
      peakActive <= 1'b1;
      mv(16'hFFE2, 4, 4'h1);
   endtask

   initial begin
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      t_regs();
      t_single();
      t_window();
      t_delay();
      t_crit();
      t_remote();
      test_done();
   end
endmodule
